// ---- rtl/atp_config.sv ----
// Test-pattern, fast overload and link configuration logic of a dual ADC
//
// Summary of operation
// - Channel A 4-bit selector: 0000 samples, 0001 zeros, 0010 ones.
// - Patterns are 16-bit; 14-bit variant forces the two LSBs to 00.
// - Code 0011 alternates two complementary alternating-bit words.
// - Code 0100 ramps; 16-bit every clock, 14-bit every fourth clock.
// - Code 0110 sends word one, 0111 alternates words one and two.
// - Code 1000 sends deskew word AAAAh or 3AAAh by variant.
// - Code 1010 sends pseudo-random numbers.
// - Code 1011 repeats an eight-value sine table per variant.
// - Channel B selector in the low nibble, independent of channel A.
// - Two shared 16-bit custom words built from high and low bytes.
// - Overload flagged when level exceeds full scale times field over 127.
// - Overload indication appears nine clock cycles after the condition.
// - Two-bit transport test select: normal, clock, encoded, PRBS15.
// - While sync is asserted send 0xBCBC, or 0xBC50 with idle bit set.
// - Long-test bit enables the long transport test pattern.
// - Bit-flip control reverses the bit order of output sample words.
// - Enable bits insert lane and frame alignment characters.
// - On sync release send alignment sequence unless disable bit set.
// - Override bits enable software frames and octets per frame values.
// - Scramble enable bit, cleared at reset.
// - Frames per multiframe 5-bit, default 16 or 8, never lowered.
`timescale 1ns/10ps
`default_nettype none
module atp_config #(
    parameter int RES_BITS = 16
) (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_n_in,
    // Serial configuration pins
    input  wire logic        cfg_sen_n_in,
    input  wire logic        cfg_sclk_in,
    input  wire logic        cfg_sdata_in,
    output logic             cfg_sdout_out,
    output logic             cfg_sdout_oe_out,
    // Converter samples
    input  wire logic [15:0] chan_a_sample_in,
    input  wire logic [15:0] chan_b_sample_in,
    // Link input data
    output logic      [15:0] chan_a_data_out,
    output logic      [15:0] chan_b_data_out,
    // Fast overload
    output logic             overload_out_a,
    output logic             overload_out_b,
    // Link control
    input  wire logic        sync_n_in,
    output logic      [15:0] sync_word_out,
    output logic             send_sync_out,
    output logic             initial_align_sequence_out,
    output logic      [1:0]  transport_test_sel_out,
    output logic             long_test_enable_out,
    output logic             lane_align_char_en_out,
    output logic             frame_align_char_en_out,
    output logic             scramble_en_out,
    output logic      [1:0]  octets_per_frame_out,
    output logic      [4:0]  frames_per_multiframe_out
);
    // ========================================================
    // Checks and functions
    localparam bit LOW14 = (RES_BITS == 14);

    initial
    begin
        if (RES_BITS != 14 && RES_BITS != 16)
            $error("RES_BITS must be 14 or 16");
    end

    function automatic logic [15:0] bit_reverse(input logic [15:0] w);
        logic [15:0] r;
        r = '0;
        for (int i = 0; i < 16; i++)
            r[i] = w[15 - i];
        return r;
    endfunction

    function automatic logic [15:0] sine_value(input logic [2:0] idx);
        logic [15:0] v;
        v = '0;
        case (idx)
            3'h0: v = LOW14 ? 16'h0000 : 16'h0001;
            3'h1, 3'h7: v = LOW14 ? 16'h095F : 16'h257E;
            3'h2, 3'h6: v = LOW14 ? 16'h2000 : 16'h8000;
            3'h3, 3'h5: v = LOW14 ? 16'h36A0 : 16'hDA82;
            3'h4: v = LOW14 ? 16'h3FFF : 16'hFFFF;
            default: v = '0;
        endcase
        return LOW14 ? {v[13:0], 2'b00} : v;
    endfunction

    // ========================================================
    // Pin synchronisers
    logic [1:0] sen_s_r;
    logic [1:0] sclk_s_r;
    logic [1:0] sdata_s_r;
    logic [1:0] sync_s_r;
    logic       sclk_d_r;
    logic       sync_d_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            sen_s_r   <= 2'h3;
            sclk_s_r  <= 2'h0;
            sdata_s_r <= 2'h0;
            sync_s_r  <= 2'h0;
            sclk_d_r  <= 1'b0;
            sync_d_r  <= 1'b0;
        end
        else
        begin
            sen_s_r   <= {sen_s_r[0], cfg_sen_n_in};
            sclk_s_r  <= {sclk_s_r[0], cfg_sclk_in};
            sdata_s_r <= {sdata_s_r[0], cfg_sdata_in};
            sync_s_r  <= {sync_s_r[0], sync_n_in};
            sclk_d_r  <= sclk_s_r[1];
            sync_d_r  <= sync_s_r[1];
        end
    end

    wire sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    wire sclk_fall = ~sclk_s_r[1] & sclk_d_r;
    wire sel_on    = ~sen_s_r[1];

    // ========================================================
    // Serial frame: read flag, 7-bit address, 8-bit data
    logic [15:0] shift_r;
    logic [4:0]  bit_cnt_r;
    logic        rd_r;
    logic [6:0]  addr_r;
    logic [7:0]  rd_byte_r;
    logic [7:0]  rd_byte_nxt;
    logic        wr_stb;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [15:0] shift_nxt;

    assign shift_nxt = {shift_r[14:0], sdata_s_r[1]};
    assign wr_stb    = sel_on & sclk_rise & (bit_cnt_r == 5'h0F) & ~rd_r;
    assign wr_addr   = addr_r;
    assign wr_data   = shift_nxt[7:0];

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
            rd_r      <= 1'b0;
            addr_r    <= '0;
            rd_byte_r <= '0;
        end
        else if (!sel_on)
            bit_cnt_r <= '0;
        else if (sclk_rise && bit_cnt_r != 5'h10)
        begin
            shift_r   <= shift_nxt;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            if (bit_cnt_r == 5'h07)
            begin
                rd_r      <= shift_nxt[7];
                addr_r    <= shift_nxt[6:0];
                rd_byte_r <= rd_byte_nxt;
            end
        end
    end

    // Read data shifts out on falling clock so it is stable at rising
    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            cfg_sdout_out <= 1'b0;
        else if (sel_on && sclk_fall && bit_cnt_r[3])
            cfg_sdout_out <= rd_byte_r[~bit_cnt_r[2:0]];
    end

    assign cfg_sdout_oe_out = sel_on & rd_r & bit_cnt_r[3];

    // ========================================================
    // Registers
    logic [7:0] pat_sel_r;
    logic [7:0] w1_hi_r;
    logic [7:0] w1_lo_r;
    logic [7:0] w2_hi_r;
    logic [7:0] w2_lo_r;
    logic [7:0] thr_r;
    logic [7:0] link_ctrl_r;
    logic [1:0] override_r;
    logic       scramble_r;
    logic       opf_r;
    logic [4:0] kreg_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pat_sel_r   <= atp_pkg::RST_ZERO;
            w1_hi_r     <= atp_pkg::RST_ZERO;
            w1_lo_r     <= atp_pkg::RST_ZERO;
            w2_hi_r     <= atp_pkg::RST_ZERO;
            w2_lo_r     <= atp_pkg::RST_ZERO;
            thr_r       <= atp_pkg::RST_THRESHOLD;
            link_ctrl_r <= atp_pkg::RST_ZERO;
            override_r  <= '0;
            scramble_r  <= 1'b0;
            opf_r       <= 1'b0;
            kreg_r      <= '0;
        end
        else if (wr_stb)
        begin
            case (wr_addr)
                atp_pkg::OFS_TEST_PATTERN_SELECT:  pat_sel_r <= wr_data;
                atp_pkg::OFS_CUSTOM_WORD1_HIGH:    w1_hi_r <= wr_data;
                atp_pkg::OFS_CUSTOM_WORD1_LOW:     w1_lo_r <= wr_data;
                atp_pkg::OFS_CUSTOM_WORD2_HIGH:    w2_hi_r <= wr_data;
                atp_pkg::OFS_CUSTOM_WORD2_LOW:     w2_lo_r <= wr_data;
                atp_pkg::OFS_OVERLOAD_THRESHOLD:   thr_r <= wr_data;
                atp_pkg::OFS_LINK_TEST_ALIGN_CTRL: link_ctrl_r <= wr_data;
                atp_pkg::OFS_FRAME_PARAM_OVERRIDE: override_r <= wr_data[1:0];
                atp_pkg::OFS_SCRAMBLER_CTRL:
                    scramble_r <= wr_data[atp_pkg::SCRAMBLE_BIT];
                atp_pkg::OFS_OCTETS_PER_FRAME:
                    opf_r <= wr_data[atp_pkg::OPF_BIT];
                atp_pkg::OFS_FRAMES_PER_MULTI:     kreg_r <= wr_data[4:0];
                default: ;
            endcase
        end
    end

    // Unmapped addresses read as zero
    always_comb
    begin
        rd_byte_nxt = 8'h00;
        case (shift_nxt[6:0])
            atp_pkg::OFS_TEST_PATTERN_SELECT:  rd_byte_nxt = pat_sel_r;
            atp_pkg::OFS_CUSTOM_WORD1_HIGH:    rd_byte_nxt = w1_hi_r;
            atp_pkg::OFS_CUSTOM_WORD1_LOW:     rd_byte_nxt = w1_lo_r;
            atp_pkg::OFS_CUSTOM_WORD2_HIGH:    rd_byte_nxt = w2_hi_r;
            atp_pkg::OFS_CUSTOM_WORD2_LOW:     rd_byte_nxt = w2_lo_r;
            atp_pkg::OFS_OVERLOAD_THRESHOLD:   rd_byte_nxt = thr_r;
            atp_pkg::OFS_LINK_TEST_ALIGN_CTRL: rd_byte_nxt = link_ctrl_r;
            atp_pkg::OFS_FRAME_PARAM_OVERRIDE:
                rd_byte_nxt = {6'h00, override_r};
            atp_pkg::OFS_SCRAMBLER_CTRL:   rd_byte_nxt = {scramble_r, 7'h00};
            atp_pkg::OFS_OCTETS_PER_FRAME: rd_byte_nxt = {7'h00, opf_r};
            atp_pkg::OFS_FRAMES_PER_MULTI: rd_byte_nxt = {3'h0, kreg_r};
            default: rd_byte_nxt = 8'h00;
        endcase
    end

    // ========================================================
    // Shared pattern sources
    wire [15:0] user_word_one = {w1_hi_r, w1_lo_r};
    wire [15:0] user_word_two = {w2_hi_r, w2_lo_r};
    logic [15:0] ramp_r;
    logic [1:0]  ramp_div_r;
    logic        phase_r;
    logic [2:0]  sine_idx_r;
    logic [14:0] prbs_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ramp_r     <= '0;
            ramp_div_r <= '0;
            phase_r    <= 1'b0;
            sine_idx_r <= '0;
            prbs_r     <= atp_pkg::PRBS_SEED;
        end
        else
        begin
            ramp_div_r <= ramp_div_r + 2'h1;
            if (!LOW14 || ramp_div_r == 2'h3)
                ramp_r <= LOW14 ? {2'h0, ramp_r[13:0] + 14'h0001}
                                : ramp_r + 16'h0001;
            phase_r    <= ~phase_r;
            sine_idx_r <= sine_idx_r + 3'h1;
            prbs_r     <= {prbs_r[13:0], prbs_r[14] ^ prbs_r[13]};
        end
    end

    function automatic logic [15:0] pattern_word(input logic [3:0] sel,
                                                 input logic [15:0] samp);
        logic [15:0] w;
        w = samp;
        case (sel)
            atp_pkg::PAT_NORMAL: w = samp;
            atp_pkg::PAT_ZEROS:  w = 16'h0000;
            atp_pkg::PAT_ONES:   w = 16'hFFFF;
            atp_pkg::PAT_TOGGLE:
                w = phase_r ? ~atp_pkg::TOGGLE_WORD : atp_pkg::TOGGLE_WORD;
            atp_pkg::PAT_RAMP:
                w = LOW14 ? {ramp_r[13:0], 2'b00} : ramp_r;
            atp_pkg::PAT_SINGLE: w = user_word_one;
            atp_pkg::PAT_DOUBLE:
                w = phase_r ? user_word_two : user_word_one;
            atp_pkg::PAT_DESKEW:
                w = LOW14 ? {atp_pkg::DESKEW_14, 2'b00} : atp_pkg::DESKEW_16;
            atp_pkg::PAT_PRBS:   w = {prbs_r, prbs_r[14]};
            atp_pkg::PAT_SINE:   w = sine_value(sine_idx_r);
            default: w = samp;
        endcase
        if (LOW14 && sel != atp_pkg::PAT_NORMAL)
            w[1:0] = 2'b00;
        return w;
    endfunction

    // ========================================================
    // Output sample words
    wire [3:0] sel_a = pat_sel_r[atp_pkg::CHA_SEL_LSB +: 4];
    wire [3:0] sel_b = pat_sel_r[atp_pkg::CHB_SEL_LSB +: 4];
    wire       flip  = link_ctrl_r[atp_pkg::FLIP_BIT];
    logic [15:0] word_a;
    logic [15:0] word_b;

    // Process form so counters read inside the function also wake it
    always_comb
    begin
        word_a = pattern_word(sel_a, chan_a_sample_in);
        word_b = pattern_word(sel_b, chan_b_sample_in);
    end

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            chan_a_data_out <= '0;
            chan_b_data_out <= '0;
        end
        else
        begin
            chan_a_data_out <= flip ? bit_reverse(word_a) : word_a;
            chan_b_data_out <= flip ? bit_reverse(word_b) : word_b;
        end
    end

    // ========================================================
    // Fast overload: |x| * 127 > thr * 32768, compared without division
    function automatic logic over_level(input logic [15:0] s,
                                        input logic [6:0] thr);
        logic [15:0] mag;
        logic [22:0] lhs;
        logic [22:0] rhs;
        mag = s[15] ? (~s + 16'h0001) : s;
        lhs = 23'(mag) * 23'(atp_pkg::THR_FULL_DIV);
        rhs = {1'b0, thr, 15'h0000};
        return lhs > rhs;
    endfunction

    wire ovr_raw_a = over_level(chan_a_sample_in, thr_r[6:0]);
    wire ovr_raw_b = over_level(chan_b_sample_in, thr_r[6:0]);
    logic [atp_pkg::OVR_LATENCY-1:0] ovr_pipe_a_r;
    logic [atp_pkg::OVR_LATENCY-1:0] ovr_pipe_b_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ovr_pipe_a_r <= '0;
            ovr_pipe_b_r <= '0;
        end
        else
        begin
            ovr_pipe_a_r <= {ovr_pipe_a_r[atp_pkg::OVR_LATENCY-2:0],
                             ovr_raw_a};
            ovr_pipe_b_r <= {ovr_pipe_b_r[atp_pkg::OVR_LATENCY-2:0],
                             ovr_raw_b};
        end
    end

    assign overload_out_a = ovr_pipe_a_r[atp_pkg::OVR_LATENCY-1];
    assign overload_out_b = ovr_pipe_b_r[atp_pkg::OVR_LATENCY-1];

    // ========================================================
    // Link control
    logic ila_r;

    always_ff @(posedge clock_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            ila_r <= 1'b0;
        else
            ila_r <= sync_s_r[1] & ~sync_d_r
                     & ~link_ctrl_r[atp_pkg::ILA_DISABLE_BIT];
    end

    assign initial_align_sequence_out = ila_r;
    assign send_sync_out = ~sync_s_r[1];
    assign sync_word_out = link_ctrl_r[atp_pkg::IDLE_SYNC_BIT]
                           ? atp_pkg::SYNC_ALT : atp_pkg::SYNC_K28_5;
    assign transport_test_sel_out =
        link_ctrl_r[atp_pkg::TTEST_LSB +: 2];
    assign long_test_enable_out =
        link_ctrl_r[atp_pkg::LONG_TEST_BIT];
    assign lane_align_char_en_out =
        link_ctrl_r[atp_pkg::LANE_ALIGN_BIT];
    assign frame_align_char_en_out =
        link_ctrl_r[atp_pkg::FRAME_ALIGN_BIT];
    assign scramble_en_out = scramble_r;

    wire mode20 = override_r[atp_pkg::CTRL_F_BIT] & opf_r;
    wire [4:0] k_min = mode20 ? atp_pkg::K_MIN_20X : atp_pkg::K_MIN_10X;
    assign octets_per_frame_out = mode20 ? 2'h2 : 2'h1;
    // Lower programmed values are clamped rather than trusted
    assign frames_per_multiframe_out =
        (override_r[atp_pkg::CTRL_K_BIT] && kreg_r > k_min)
        ? kreg_r : k_min;

    // ========================================================
    // Assertions
    default clocking cb_main @(posedge clock_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_ovr_event_a;
        ovr_raw_a;
    endsequence

    sequence s_ila_pulse;
        initial_align_sequence_out ##1 !initial_align_sequence_out;
    endsequence

    a_ovr_latency: assert property (
        s_ovr_event_a |-> ##9 overload_out_a)
        else $error("overload not flagged nine cycles later");
    a_zero_pattern: assert property (
        sel_a == atp_pkg::PAT_ZEROS |=> chan_a_data_out == 16'h0000)
        else $error("zero pattern wrong");
    a_deskew_word: assert property (
        (sel_b == atp_pkg::PAT_DESKEW && !flip) |=>
        chan_b_data_out == (LOW14 ? 16'hEAA8 : 16'hAAAA))
        else $error("deskew word wrong");
    a_toggle_alt: assert property (
        (sel_b == atp_pkg::PAT_TOGGLE && !flip)[*2] |=>
        chan_b_data_out ==
        (~$past(chan_b_data_out) & (LOW14 ? 16'hFFFC : 16'hFFFF)))
        else $error("toggle not complementary");
    a_ramp_step: assert property (
        (!LOW14 && sel_a == atp_pkg::PAT_RAMP && !flip)[*2] |=>
        chan_a_data_out == $past(chan_a_data_out) + 16'h0001)
        else $error("ramp step wrong");
    a_sync_code: assert property (
        send_sync_out |-> sync_word_out ==
        (link_ctrl_r[5] ? 16'hBC50 : 16'hBCBC))
        else $error("sync code wrong");
    a_ila_start: assert property (
        $rose(sync_s_r[1]) && !link_ctrl_r[0] |=> s_ila_pulse)
        else $error("alignment sequence start wrong");
    a_k_floor: assert property (
        frames_per_multiframe_out >=
        (octets_per_frame_out == 2'h2 ? 5'h08 : 5'h10))
        else $error("frames per multiframe below floor");
    a_flip_order: assert property (
        (flip && sel_a == atp_pkg::PAT_ONES
         && sel_b == atp_pkg::PAT_DESKEW && !LOW14)
        |=> chan_b_data_out == 16'h5555)
        else $error("bit flip wrong");
endmodule
`default_nettype wire

// ---- rtl/atp_pkg.sv ----
// Package: register map, pattern codes and constants for the test-pattern block
package atp_pkg;
    // ========================================================
    // Register offsets
    localparam logic [6:0] OFS_TEST_PATTERN_SELECT  = 7'h0F;
    localparam logic [6:0] OFS_CUSTOM_WORD1_HIGH    = 7'h10;
    localparam logic [6:0] OFS_CUSTOM_WORD1_LOW     = 7'h11;
    localparam logic [6:0] OFS_CUSTOM_WORD2_HIGH    = 7'h12;
    localparam logic [6:0] OFS_CUSTOM_WORD2_LOW     = 7'h13;
    localparam logic [6:0] OFS_OVERLOAD_THRESHOLD   = 7'h1F;
    localparam logic [6:0] OFS_LINK_TEST_ALIGN_CTRL = 7'h26;
    localparam logic [6:0] OFS_FRAME_PARAM_OVERRIDE = 7'h27;
    localparam logic [6:0] OFS_SCRAMBLER_CTRL       = 7'h2B;
    localparam logic [6:0] OFS_OCTETS_PER_FRAME     = 7'h2C;
    localparam logic [6:0] OFS_FRAMES_PER_MULTI     = 7'h2D;
    // ========================================================
    // Reset values
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [7:0] RST_THRESHOLD = 8'hFF;
    // ========================================================
    // Field positions
    localparam int CHA_SEL_LSB      = 4;
    localparam int CHB_SEL_LSB      = 0;
    localparam int THR_WRITE0_BIT   = 7;
    localparam int TTEST_LSB        = 6;
    localparam int IDLE_SYNC_BIT    = 5;
    localparam int LONG_TEST_BIT    = 4;
    localparam int FLIP_BIT         = 3;
    localparam int LANE_ALIGN_BIT   = 2;
    localparam int FRAME_ALIGN_BIT  = 1;
    localparam int ILA_DISABLE_BIT  = 0;
    localparam int CTRL_K_BIT       = 1;
    localparam int CTRL_F_BIT       = 0;
    localparam int SCRAMBLE_BIT     = 7;
    localparam int OPF_BIT          = 0;
    // ========================================================
    // Pattern selector codes
    typedef enum logic [3:0] {
        PAT_NORMAL = 4'h0, PAT_ZEROS  = 4'h1, PAT_ONES   = 4'h2,
        PAT_TOGGLE = 4'h3, PAT_RAMP   = 4'h4, PAT_SINGLE = 4'h6,
        PAT_DOUBLE = 4'h7, PAT_DESKEW = 4'h8, PAT_PRBS   = 4'hA,
        PAT_SINE   = 4'hB
    } atp_pattern_t;
    // ========================================================
    // Pattern data and link constants
    localparam logic [15:0] TOGGLE_WORD  = 16'hAAAA;
    localparam logic [15:0] DESKEW_16    = 16'hAAAA;
    localparam logic [13:0] DESKEW_14    = 14'h3AAA;
    localparam logic [15:0] SYNC_K28_5   = 16'hBCBC;
    localparam logic [15:0] SYNC_ALT     = 16'hBC50;
    localparam logic [4:0]  K_MIN_10X    = 5'h10;
    localparam logic [4:0]  K_MIN_20X    = 5'h08;
    localparam logic [6:0]  THR_FULL_DIV = 7'h7F;
    localparam int          OVR_LATENCY  = 9;
    localparam logic [14:0] PRBS_SEED    = 15'h7FFF;
endpackage

// ---- tb/atp_rx_model.sv ----
// Link receiver model: holds sync low after reset or relink, then releases
`timescale 1ns/10ps
`default_nettype none
module atp_rx_model (
    // Clock and reset
    input  wire logic clock_in,
    input  wire logic rst_n_in,
    // Relink request from the bench
    input  wire logic relink_in,
    // Sync request, active low
    output logic      sync_n_out
);
    logic [3:0] hold_r;
    // =========================================
    // Sync hold counter
    // Held long enough for the device's two-stage synchroniser
    always_ff @(posedge clock_in or negedge rst_n_in)
        if (!rst_n_in)
            hold_r <= 4'hF;
        else if (relink_in)
            hold_r <= 4'hF;
        else if (hold_r != 4'h0)
            hold_r <= hold_r - 4'h1;
    assign sync_n_out = (hold_r == 4'h0);
endmodule
`default_nettype wire

// ---- tb/atp_config_tb.sv ----
// Bench for the test-pattern and link configuration block
`timescale 1ns/10ps
`default_nettype none
module atp_config_tb;
    logic clock_in = 0, rst_n_in = 0, sen_n = 1, sclk = 0, sdata = 0;
    logic relink = 0, sdout, sdout_oe, ovr_a, ovr_b, ssync, initial_align_sequence, lng;
    logic lane, frame, scr, sync_n;
    logic [15:0] samp_a = 16'h0000, samp_b = 16'h0000, da, db, sw, x;
    logic [1:0]  tsel, opf;
    logic [4:0]  fpm;
    logic [7:0]  rd;
    logic [31:0] acc;
    int miscompares = 0, check_count = 0, n;
    always #5 clock_in = ~clock_in;
    atp_rx_model rx_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .relink_in(relink), .sync_n_out(sync_n));
    atp_config dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .cfg_sen_n_in(sen_n), .cfg_sclk_in(sclk), .cfg_sdata_in(sdata),
        .cfg_sdout_out(sdout), .cfg_sdout_oe_out(sdout_oe),
        .chan_a_sample_in(samp_a), .chan_b_sample_in(samp_b),
        .chan_a_data_out(da), .chan_b_data_out(db),
        .overload_out_a(ovr_a), .overload_out_b(ovr_b),
        .sync_n_in(sync_n), .sync_word_out(sw), .send_sync_out(ssync),
        .initial_align_sequence_out(initial_align_sequence), .transport_test_sel_out(tsel),
        .long_test_enable_out(lng), .lane_align_char_en_out(lane),
        .frame_align_char_en_out(frame), .scramble_en_out(scr),
        .octets_per_frame_out(opf), .frames_per_multiframe_out(fpm));
    // =========================================
    // Compare and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock_in);
    endtask
    // Frame: rw bit, 7-bit address, 8 data bits; read bits caught late
    task automatic xfer(input logic [15:0] w);
        sen_n = 0;
        for (int i = 15; i >= 0; i--)
        begin
            sclk = 0;
            sdata = w[i];
            cyc(6);
            if (i < 8)
                rd[i] = sdout;
            if (i == 0)
                chk(sdout_oe, w[15]);
            sclk = 1;
            cyc(5);
        end
        sclk = 0;
        cyc(5);
        sen_n = 1;
        cyc(6);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        xfer({1'b0, a, d});
    endtask
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        xfer({1'b1, a, 8'h00});
        chk(rd, e);
    endtask
    task automatic ila_count(input logic relink_now);
        relink = relink_now;
        cyc(1);
        relink = 0;
        n = 0;
        repeat (40)
        begin
            @(negedge clock_in);
            n += initial_align_sequence;
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // =========================================
    // Main sequence
    initial
    begin
        cyc(20);
        rst_n_in = 1;
        cyc(4);
        rdc(atp_pkg::OFS_OVERLOAD_THRESHOLD, 8'hFF);
        rdc(atp_pkg::OFS_SCRAMBLER_CTRL, 8'h00);
        rdc(7'h05, 8'h00);
        chk({scr, opf, fpm}, {1'b0, 2'd1, 5'd16});
        $display("reset test done");
        samp_a = 16'h1234;
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'h12);
        chk({da, db}, {16'h0000, 16'hFFFF});
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'h08);
        chk({da, db}, {16'h1234, 16'hAAAA});
        wr(atp_pkg::OFS_CUSTOM_WORD1_HIGH, 8'hC3);
        wr(atp_pkg::OFS_CUSTOM_WORD1_LOW, 8'h5A);
        wr(atp_pkg::OFS_CUSTOM_WORD2_HIGH, 8'h0F);
        wr(atp_pkg::OFS_CUSTOM_WORD2_LOW, 8'h81);
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'h67);
        x = db;
        cyc(1);
        chk({da, db ^ x}, {16'hC35A, 16'hC35A ^ 16'h0F81});
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'h43);
        acc = {da, db};
        cyc(1);
        chk(da, 16'(acc[31:16] + 16'h0001));
        chk(db, 16'(~acc[15:0]));
        chk(db ^ {db[14:0], db[15]}, 16'hFFFF);
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'hBA);
        acc = 0;
        repeat (8)
        begin
            acc += da;
            cyc(1);
        end
        chk(acc, 32'h40000);
        x = db;
        cyc(1);
        chk(db[15:1], {x[14:1], x[15] ^ x[14]});
        $display("pattern tests done");
        wr(atp_pkg::OFS_OVERLOAD_THRESHOLD, 8'h3F);
        samp_a = 16'h7FFF;
        samp_b = 16'h1000;
        cyc(12);
        chk({ovr_a, ovr_b}, 2'b10);
        samp_a = 16'h0000;
        cyc(12);
        chk(ovr_a, 1'b0);
        $display("overload test done");
        wr(atp_pkg::OFS_LINK_TEST_ALIGN_CTRL, 8'hFE);
        wr(atp_pkg::OFS_SCRAMBLER_CTRL, 8'hFF);
        rdc(atp_pkg::OFS_SCRAMBLER_CTRL, 8'h80);
        chk({tsel, lng, lane, frame, scr, sw}, {6'h3F, 16'hBC50});
        wr(atp_pkg::OFS_TEST_PATTERN_SELECT, 8'h28);
        chk({da, db}, {16'hFFFF, 16'h5555});
        wr(atp_pkg::OFS_FRAME_PARAM_OVERRIDE, 8'h03);
        wr(atp_pkg::OFS_OCTETS_PER_FRAME, 8'h01);
        wr(atp_pkg::OFS_FRAMES_PER_MULTI, 8'h04);
        chk({opf, fpm}, {2'd2, 5'd8});
        ila_count(1'b1);
        chk({n[1:0], ssync}, 3'b010);
        wr(atp_pkg::OFS_LINK_TEST_ALIGN_CTRL, 8'h01);
        relink = 1;
        cyc(4);
        chk({ssync, sw}, {1'b1, 16'hBCBC});
        ila_count(1'b0);
        chk(n[1:0], 2'd0);
        $display("link test done");
        conclude();
    end
endmodule
`default_nettype wire
